// *** src/rdsc_pkg.sv ***
// Purpose: Constants and carriers for the receive path configuration.
// Assumes: One clock, synchronous active-high reset.
// Notes: Register offsets are byte addresses on the plain register port.
package rdsc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_DEMOD_OFS = 8'h19;
    localparam logic [7:0] REG_SYNC_OFS = 8'h1a;
    localparam logic [7:0] REG_DEMOD_RST = 8'h4d;
    localparam logic [7:0] REG_SYNC_RST = 8'h00;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int USE_MSB = 7;
    localparam int USE_LSB = 6;
    localparam int PIN_BIT = 5;
    localparam int EVEN_BIT = 4;
    localparam int RXTC_MSB = 3;
    localparam int RXTC_LSB = 2;
    localparam int BTC_MSB = 1;
    localparam int BTC_LSB = 0;
    localparam int SYNC_MSB = 7;
    localparam int SYNC_LSB = 6;
    localparam int MINL_MSB = 5;
    localparam int MINL_LSB = 0;
    // ----------------------------------------------------------------
    // Encodings and sync bytes
    // ----------------------------------------------------------------
    localparam logic [1:0] USE_STRONG = 2'h0;
    localparam logic [1:0] USE_FREEZE = 2'h1;
    localparam logic [1:0] USE_COMBINE = 2'h2;
    localparam logic [1:0] TC_FROZEN = 2'h0;
    localparam logic [7:0] SYNC_HI = 8'hb2;
    localparam logic [7:0] SYNC_LO = 8'h4d;
    localparam logic [7:0] SYNC_PAD = 8'h00;
    localparam int LEN_SCALE = 4;

    typedef enum logic [3:0] {
        RDSC_SRC_I = 4'h1,
        RDSC_SRC_Q = 4'h2,
        RDSC_SRC_SUM = 4'h4,
        RDSC_SRC_NONE = 4'h8
    } rdsc_src_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rdsc_bus_s;

    typedef struct packed {
        logic valid;
        logic [8:0] length;
    } rdsc_pkt_s;
endpackage

// *** src/rdsc_top.sv ***
// Purpose: Demodulator and sync configuration registers with their
//          effects on channel choice, timer tick, loop freeze and
//          packet filtering.
// Assumes: Strength inputs, rate and mode flags come from core logic
//          on CLK; no synchronisers are needed.
// Notes: Read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
module rdsc_top
    import rdsc_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Receive path status from the core
    input wire logic [7:0] I_STRENGTH,
    input wire logic [7:0] Q_STRENGTH,
    input wire logic COMM_ACTIVE,
    input wire logic RX_ACTIVE,
    input wire logic RATE_106K,
    input wire logic SYNC_DETECT_ENABLE,
    input wire logic [7:0] TIMER_DIVIDER_VALUE,
    // Packet length check
    input wire logic PKT_DONE,
    input wire logic [8:0] PKT_LENGTH,
    // Outputs to the receive path
    output logic [3:0] RX_SOURCE,
    output logic TIMER_TICK,
    output logic LOOP_FREEZE,
    output logic [1:0] RX_LOOP_TIME_CONSTANT,
    output logic [1:0] BURST_LOOP_TIME_CONSTANT,
    output logic [39:0] SYNC_PATTERN,
    output logic [2:0] SYNC_BYTES_EXTRA,
    output logic PKT_ACCEPT,
    output logic PKT_DISCARD
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    rdsc_bus_s bus;
    logic [7:0] demodulator_settings;
    logic [7:0] sync_and_min_length;
    logic [1:0] channel_use_select;
    logic channel_pin;
    logic even_prescale;
    logic [1:0] sync_pattern_length;
    logic [5:0] min_packet_length;

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign channel_use_select = demodulator_settings[USE_MSB:USE_LSB];
    assign channel_pin = demodulator_settings[PIN_BIT];
    assign even_prescale = demodulator_settings[EVEN_BIT];
    assign sync_pattern_length = sync_and_min_length[SYNC_MSB:SYNC_LSB];
    assign min_packet_length = sync_and_min_length[MINL_MSB:MINL_LSB];

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            demodulator_settings <= REG_DEMOD_RST;
            sync_and_min_length <= REG_SYNC_RST;
        end
        else if (bus.wr)
        begin
            if (bus.addr == REG_DEMOD_OFS)
                demodulator_settings <= bus.wdata;
            if (bus.addr == REG_SYNC_OFS)
                sync_and_min_length <= bus.wdata;
        end
    end

    // Unmapped addresses read as zero.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            RDATA <= 8'h00;
        else if (bus.rd && bus.addr == REG_DEMOD_OFS)
            RDATA <= demodulator_settings;
        else if (bus.rd && bus.addr == REG_SYNC_OFS)
            RDATA <= sync_and_min_length;
        else
            RDATA <= 8'h00;
    end

    // ----------------------------------------------------------------
    // Channel selection
    // ----------------------------------------------------------------
    logic q_stronger;
    logic held_q;
    logic held_valid;
    rdsc_src_e next_src;

    assign q_stronger = Q_STRENGTH > I_STRENGTH;

    // The frozen choice is taken at the first cycle of a communication
    // and released when it ends, so each exchange chooses afresh.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            held_q <= 1'b0;
            held_valid <= 1'b0;
        end
        else if (!COMM_ACTIVE)
            held_valid <= 1'b0;
        else if (!held_valid)
        begin
            held_q <= q_stronger;
            held_valid <= 1'b1;
        end
    end

    // Reserved encoding 11, when the channel is not pinned, reports no source instead of guessing, so a
    // misprogrammed field shows up downstream rather than hiding.
    always_comb
    begin
        next_src = RDSC_SRC_NONE;
        if (channel_pin)
            next_src = channel_use_select[0] ? RDSC_SRC_Q : RDSC_SRC_I;
        else
        begin
            case (channel_use_select)
                USE_STRONG:
                    next_src = q_stronger ? RDSC_SRC_Q : RDSC_SRC_I;
                USE_FREEZE:
                begin
                    if (held_valid)
                        next_src = held_q ? RDSC_SRC_Q : RDSC_SRC_I;
                    else
                        next_src = q_stronger ? RDSC_SRC_Q : RDSC_SRC_I;
                end
                USE_COMBINE:
                    next_src = RDSC_SRC_SUM;
                default:
                    next_src = RDSC_SRC_NONE;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            RX_SOURCE <= RDSC_SRC_I;
        else
            RX_SOURCE <= next_src;
    end

    // ----------------------------------------------------------------
    // Timer prescaler
    // ----------------------------------------------------------------
    // CLK stands in for the 13.56 MHz reference; the period is
    // 2 * divider + 1 or + 2 clocks, so the tick is one clock wide.
    logic [8:0] tick_count;
    logic [8:0] tick_last;

    always_comb
    begin
        tick_last = {TIMER_DIVIDER_VALUE, 1'b0};
        if (even_prescale)
            tick_last = {TIMER_DIVIDER_VALUE, 1'b1};
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            tick_count <= 9'h000;
            TIMER_TICK <= 1'b0;
        end
        else if (tick_count >= tick_last)
        begin
            tick_count <= 9'h000;
            TIMER_TICK <= 1'b1;
        end
        else
        begin
            tick_count <= tick_count + 9'h001;
            TIMER_TICK <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Loop time constants and sync pattern
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            LOOP_FREEZE <= 1'b0;
            RX_LOOP_TIME_CONSTANT <= REG_DEMOD_RST[RXTC_MSB:RXTC_LSB];
            BURST_LOOP_TIME_CONSTANT <= REG_DEMOD_RST[BTC_MSB:BTC_LSB];
        end
        else
        begin
            LOOP_FREEZE <= RX_ACTIVE
                && demodulator_settings[RXTC_MSB:RXTC_LSB] == TC_FROZEN;
            RX_LOOP_TIME_CONSTANT <= demodulator_settings[RXTC_MSB:RXTC_LSB];
            BURST_LOOP_TIME_CONSTANT <= demodulator_settings[BTC_MSB:BTC_LSB];
        end
    end

    // Pattern is right aligned: the low 16 bits are always B2 4D.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            SYNC_PATTERN <= {SYNC_PAD, SYNC_PAD, SYNC_PAD, SYNC_HI, SYNC_LO};
            SYNC_BYTES_EXTRA <= 3'h0;
        end
        else
        begin
            SYNC_PATTERN <= {SYNC_PAD, SYNC_PAD, SYNC_PAD, SYNC_HI, SYNC_LO};
            SYNC_BYTES_EXTRA <= {1'b0, sync_pattern_length};
        end
    end

    // ----------------------------------------------------------------
    // Minimum packet length filter
    // ----------------------------------------------------------------
    logic [8:0] min_bytes;
    logic filter_off;
    rdsc_pkt_s pkt;

    assign pkt = '{valid: PKT_DONE, length: PKT_LENGTH};
    assign min_bytes = {1'b0, min_packet_length, 2'b00};
    assign filter_off = RATE_106K && !SYNC_DETECT_ENABLE;

    // Short packets are dropped silently: only the discard pulse shows it.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            PKT_ACCEPT <= 1'b0;
            PKT_DISCARD <= 1'b0;
        end
        else
        begin
            PKT_ACCEPT <= pkt.valid
                && (filter_off || pkt.length >= min_bytes);
            PKT_DISCARD <= pkt.valid && !filter_off
                && pkt.length < min_bytes;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_write_demod;
        WR && ADDR == REG_DEMOD_OFS;
    endsequence

    sequence s_write_sync;
        WR && ADDR == REG_SYNC_OFS;
    endsequence

    a_demod_readback: assert property (
        s_write_demod ##1 (RD && ADDR == REG_DEMOD_OFS && !WR)
        |=> RDATA == $past(WDATA, 2))
        else $error("Demodulator register read back wrong.");
    a_sync_write: assert property (
        WR && ADDR == REG_SYNC_OFS |=> sync_and_min_length == $past(WDATA))
        else $error("Sync register not updated.");
    a_sync_read: assert property (
        s_write_sync ##1 (RD && ADDR == REG_SYNC_OFS && !WR)
        |=> RDATA == $past(WDATA, 2))
        else $error("Sync register read back wrong.");
    a_pin_select: assert property (
        channel_pin |=> RX_SOURCE == ($past(channel_use_select[0])
            ? RDSC_SRC_Q : RDSC_SRC_I))
        else $error("Pinned channel wrong.");
    a_strong_pick: assert property (
        !channel_pin && channel_use_select == USE_STRONG
        |=> RX_SOURCE == ($past(q_stronger) ? RDSC_SRC_Q : RDSC_SRC_I))
        else $error("Stronger channel not chosen.");
    a_freeze_hold: assert property (
        !channel_pin && channel_use_select == USE_FREEZE && held_valid
        && COMM_ACTIVE && $stable(demodulator_settings)
        ##1 COMM_ACTIVE && $stable(demodulator_settings)
        |=> $stable(RX_SOURCE))
        else $error("Frozen channel changed.");
    a_combine_sel: assert property (
        !channel_pin && channel_use_select == USE_COMBINE
        |=> RX_SOURCE == RDSC_SRC_SUM)
        else $error("Channels not combined.");
    // A gap is judged only when the divider and prescale mode held still
    // across it, since a change in mid-gap legally cuts or stretches it.
    sequence s_odd_gap;
        TIMER_TICK && !even_prescale && TIMER_DIVIDER_VALUE == 8'h01
        ##1 (!even_prescale && TIMER_DIVIDER_VALUE == 8'h01) [*2];
    endsequence

    sequence s_even_gap;
        TIMER_TICK && even_prescale && TIMER_DIVIDER_VALUE == 8'h01
        ##1 (even_prescale && TIMER_DIVIDER_VALUE == 8'h01) [*3];
    endsequence

    a_tick_odd: assert property (
        s_odd_gap |-> !TIMER_TICK && !$past(TIMER_TICK) ##1 TIMER_TICK)
        else $error("Odd prescale period wrong.");
    a_tick_even: assert property (
        s_even_gap
        |-> !TIMER_TICK && !$past(TIMER_TICK) && !$past(TIMER_TICK, 2)
        ##1 TIMER_TICK)
        else $error("Even prescale period wrong.");
    a_loop_freeze: assert property (
        RX_ACTIVE && demodulator_settings[RXTC_MSB:RXTC_LSB] == TC_FROZEN
        |=> LOOP_FREEZE)
        else $error("Loop not frozen.");
    a_short_drop: assert property (
        PKT_DONE && !filter_off && PKT_LENGTH < min_bytes
        |=> PKT_DISCARD && !PKT_ACCEPT)
        else $error("Short packet accepted.");
    a_no_filter: assert property (
        PKT_DONE && filter_off |=> PKT_ACCEPT && !PKT_DISCARD)
        else $error("Filter applied at 106 kbit.");
    a_sync_len: assert property (
        1'b1 |=> SYNC_BYTES_EXTRA == {1'b0, $past(sync_pattern_length)})
        else $error("Sync length wrong.");
    a_rdata_idle: assert property (
        !RD |=> RDATA == 8'h00)
        else $error("Read data not cleared.");
    a_write_other: assert property (
        WR && ADDR != REG_DEMOD_OFS |=> $stable(demodulator_settings))
        else $error("Demodulator register hit by stray write.");
    a_freeze_latch: assert property (
        COMM_ACTIVE && !held_valid
        |=> held_valid && held_q == $past(q_stronger))
        else $error("Channel choice not latched.");
    a_held_release: assert property (
        !COMM_ACTIVE |=> !held_valid)
        else $error("Channel choice not released.");
    a_reserved_src: assert property (
        !channel_pin && channel_use_select == 2'h3
        |=> RX_SOURCE == RDSC_SRC_NONE)
        else $error("Reserved channel use not reported.");
    a_freeze_off: assert property (
        !RX_ACTIVE |=> !LOOP_FREEZE)
        else $error("Loop frozen outside reception.");
    a_long_accept: assert property (
        PKT_DONE && PKT_LENGTH >= min_bytes |=> PKT_ACCEPT && !PKT_DISCARD)
        else $error("Long packet dropped.");
    a_no_pkt: assert property (
        !PKT_DONE |=> !PKT_ACCEPT && !PKT_DISCARD)
        else $error("Packet verdict without a packet.");
endmodule

// *** sim/rdsc_tb.sv ***
// Purpose: Self-checking bench for the receive path configuration block.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes: Outputs are sampled 1 ns after an edge, once updates have landed.
`timescale 1ns/1ps
module tb;
    import rdsc_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] RDATA;
    logic [7:0] I_STRENGTH = 8'h00;
    logic [7:0] Q_STRENGTH = 8'h00;
    logic COMM_ACTIVE = 1'b0;
    logic RX_ACTIVE = 1'b0;
    logic RATE_106K = 1'b0;
    logic SYNC_DETECT_ENABLE = 1'b0;
    logic [7:0] TIMER_DIVIDER_VALUE = 8'h01;
    logic PKT_DONE = 1'b0;
    logic [8:0] PKT_LENGTH = 9'h000;
    logic [3:0] RX_SOURCE;
    logic TIMER_TICK;
    logic LOOP_FREEZE;
    logic [1:0] RX_LOOP_TIME_CONSTANT;
    logic [1:0] BURST_LOOP_TIME_CONSTANT;
    logic [39:0] SYNC_PATTERN;
    logic [2:0] SYNC_BYTES_EXTRA;
    logic PKT_ACCEPT;
    logic PKT_DISCARD;
    int mismatches = 0;
    int n_checks = 0;

    always #2.5 CLK = ~CLK;

    rdsc_top dut (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .I_STRENGTH(I_STRENGTH),
        .Q_STRENGTH(Q_STRENGTH), .COMM_ACTIVE(COMM_ACTIVE),
        .RX_ACTIVE(RX_ACTIVE), .RATE_106K(RATE_106K),
        .SYNC_DETECT_ENABLE(SYNC_DETECT_ENABLE),
        .TIMER_DIVIDER_VALUE(TIMER_DIVIDER_VALUE), .PKT_DONE(PKT_DONE),
        .PKT_LENGTH(PKT_LENGTH), .RX_SOURCE(RX_SOURCE),
        .TIMER_TICK(TIMER_TICK), .LOOP_FREEZE(LOOP_FREEZE),
        .RX_LOOP_TIME_CONSTANT(RX_LOOP_TIME_CONSTANT),
        .BURST_LOOP_TIME_CONSTANT(BURST_LOOP_TIME_CONSTANT),
        .SYNC_PATTERN(SYNC_PATTERN), .SYNC_BYTES_EXTRA(SYNC_BYTES_EXTRA),
        .PKT_ACCEPT(PKT_ACCEPT), .PKT_DISCARD(PKT_DISCARD));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic test_done();
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic [39:0] exp,
                       input logic [39:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk("rdata", exp, RDATA);
    endtask

    // Write then read with no gap, so the read must see the new value.
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk("rdata", d, RDATA);
    endtask

    task automatic strength(input logic [7:0] i, input logic [7:0] q);
        @(posedge CLK);
        I_STRENGTH <= i;
        Q_STRENGTH <= q;
        cyc(2);
    endtask

    // The first gap after a change may be partial, so the second counts.
    task automatic tick_gap(input logic [7:0] ctrl, input int exp);
        int n;
        wr(REG_DEMOD_OFS, ctrl);
        repeat (2)
        begin
            n = 0;
            do
            begin
                cyc(1);
                n++;
            end
            while (TIMER_TICK !== 1'b1 && n < 600);
        end
        chk("tick_gap", exp, n);
    endtask

    task automatic pkt(input logic [8:0] len, input logic acc);
        @(posedge CLK);
        PKT_DONE <= 1'b1;
        PKT_LENGTH <= len;
        @(posedge CLK);
        PKT_DONE <= 1'b0;
        #1;
        chk("accept", acc, PKT_ACCEPT);
        chk("discard", !acc, PKT_DISCARD);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        chk("rx_tc", 2'b11, RX_LOOP_TIME_CONSTANT);
        chk("burst_tc", 2'b01, BURST_LOOP_TIME_CONSTANT);
        rd_chk(REG_DEMOD_OFS, REG_DEMOD_RST);
        rd_chk(REG_SYNC_OFS, REG_SYNC_RST);
        wr(8'h1b, 8'hff);
        rd_chk(8'h1b, 8'h00);
        wr_rd(REG_DEMOD_OFS, 8'ha6);
        chk("rx_tc", 2'b01, RX_LOOP_TIME_CONSTANT);
        chk("burst_tc", 2'b10, BURST_LOOP_TIME_CONSTANT);
        wr_rd(REG_SYNC_OFS, 8'h3c);
    endtask

    // Each row: register value, I strength, Q strength, expected source.
    task automatic t_chan();
        logic [27:0] tbl [8] = '{{8'h00, 8'h10, 8'h20, RDSC_SRC_Q},
            {8'h00, 8'h30, 8'h20, RDSC_SRC_I}, {8'h80, 8'h30, 8'h20,
            RDSC_SRC_SUM}, {8'hc0, 8'h30, 8'h20, RDSC_SRC_NONE},
            {8'h20, 8'h10, 8'h20, RDSC_SRC_I}, {8'ha0, 8'h10, 8'h20,
            RDSC_SRC_I}, {8'h60, 8'h30, 8'h20, RDSC_SRC_Q},
            {8'he0, 8'h30, 8'h20, RDSC_SRC_Q}};
        foreach (tbl[k])
        begin
            wr(REG_DEMOD_OFS, tbl[k][27:20]);
            strength(tbl[k][19:12], tbl[k][11:4]);
            chk("rx_source", tbl[k][3:0], RX_SOURCE);
        end
        wr(REG_DEMOD_OFS, 8'h20);
        strength(8'h10, 8'h20);
        chk("rx_source", RDSC_SRC_I, RX_SOURCE);
        // The stronger channel must be in place before the exchange opens.
        wr(REG_DEMOD_OFS, 8'h40);
        @(posedge CLK);
        COMM_ACTIVE <= 1'b1;
        cyc(2);
        chk("rx_source", RDSC_SRC_Q, RX_SOURCE);
        strength(8'h30, 8'h20);
        chk("rx_source", RDSC_SRC_Q, RX_SOURCE);
        @(posedge CLK);
        COMM_ACTIVE <= 1'b0;
        cyc(2);
        chk("rx_source", RDSC_SRC_I, RX_SOURCE);
    endtask

    task automatic t_freeze();
        wr(REG_DEMOD_OFS, 8'h00);
        @(posedge CLK);
        RX_ACTIVE <= 1'b1;
        cyc(2);
        chk("freeze", 1'b1, LOOP_FREEZE);
        wr(REG_DEMOD_OFS, 8'h04);
        cyc(2);
        chk("freeze", 1'b0, LOOP_FREEZE);
        @(posedge CLK);
        RX_ACTIVE <= 1'b0;
    endtask

    task automatic t_timer();
        tick_gap(8'h00, 3);
        tick_gap(8'h10, 4);
        @(posedge CLK);
        TIMER_DIVIDER_VALUE <= 8'h05;
        tick_gap(8'h00, 11);
        tick_gap(8'h10, 12);
    endtask

    task automatic t_sync();
        for (int s = 0; s < 4; s++)
        begin
            wr(REG_SYNC_OFS, {s[1:0], 6'h01});
            cyc(2);
            chk("sync_extra", s[2:0], SYNC_BYTES_EXTRA);
            chk("sync_pat", 40'h000000b24d, SYNC_PATTERN);
        end
        pkt(9'h003, 1'b0);
        pkt(9'h004, 1'b1);
        @(posedge CLK);
        RATE_106K <= 1'b1;
        pkt(9'h003, 1'b1);
        @(posedge CLK);
        SYNC_DETECT_ENABLE <= 1'b1;
        pkt(9'h003, 1'b0);
        wr(REG_SYNC_OFS, 8'h3f);
        pkt(9'h0fb, 1'b0);
        pkt(9'h0fc, 1'b1);
    endtask

    // A reset in mid-run must bring both registers back to their defaults.
    task automatic t_reset();
        wr(REG_SYNC_OFS, 8'hc5);
        @(posedge CLK);
        SYS_RST <= 1'b1;
        cyc(2);
        chk("sync_extra", 3'h0, SYNC_BYTES_EXTRA);
        @(posedge CLK);
        SYS_RST <= 1'b0;
        rd_chk(REG_DEMOD_OFS, REG_DEMOD_RST);
        rd_chk(REG_SYNC_OFS, REG_SYNC_RST);
        chk("burst_tc", 2'b01, BURST_LOOP_TIME_CONSTANT);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge CLK);
        SYS_RST <= 1'b0;
        cyc(1);
        t_regs();
        t_chan();
        t_freeze();
        t_timer();
        t_sync();
        t_reset();
        test_done();
    end

    // The whole run needs well under two thousand cycles.
    initial
    begin
        #20000;
        mismatches++;
        test_done();
    end
endmodule
